// ### hw/acq_defs.svh
// Register map, field positions, reset values and timing constants of the scan sequencer
`ifndef ACQ_DEFS_SVH
`define ACQ_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define ACQ_CLK_MHZ 125
`define ACQ_TICK_US 1
`define ACQ_TICK_CYC (`ACQ_TICK_US * `ACQ_CLK_MHZ)
`define ACQ_SLOT_FAST_US 5
`define ACQ_SLOT_MID_US 10
`define ACQ_SLOT_SLOW_US 1000
`define ACQ_GAP_UNIT_US 10
`define ACQ_TABLE_DEPTH 512
`define ACQ_FIFO_DEPTH 32

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ACQ_REG_CTRL 8'h00
`define ACQ_REG_STATUS 8'h04
`define ACQ_REG_TLEN 8'h08
`define ACQ_REG_INTERVAL 8'h0C
`define ACQ_REG_ANALOG 8'h10
`define ACQ_REG_PATTERN 8'h14
`define ACQ_REG_PRETRIG 8'h18
`define ACQ_REG_TADDR 8'h1C
`define ACQ_REG_TDATA 8'h20

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define ACQ_C_RUN 0
`define ACQ_C_SYNC 1
`define ACQ_C_RATE 2
`define ACQ_C_SRC 4
`define ACQ_C_AFALL 6
`define ACQ_C_DEDGE 7
`define ACQ_C_DHIGH 8
`define ACQ_C_MODE 9
`define ACQ_C_PPORT 12
`define ACQ_C_SWTRIG 14
`define ACQ_C_STOP 15
`define ACQ_CTRL_W 14
`define ACQ_CTRL_RST 14'h0000
`define ACQ_S_RUN 0
`define ACQ_S_TRIG 1
`define ACQ_S_STATE 2
`define ACQ_S_LEVEL 8
`define ACQ_S_IDX 16
`define ACQ_A_CHAN 16
`define ACQ_P_MASK 16

`endif

// ### hw/acq_pkg.sv
// Types shared by the scan sequencer, its trigger unit and its sample buffer
package acq_pkg;

	typedef enum logic [1:0] {
		ACQ_IDLE = 2'h0,
		ACQ_ARM = 2'h1,
		ACQ_SCAN = 2'h3,
		ACQ_GAP = 2'h2
	} acq_state_e;

	typedef enum logic [1:0] {
		ACQ_SRC_SOFT = 2'h0,
		ACQ_SRC_ANALOG = 2'h1,
		ACQ_SRC_DIGITAL = 2'h2,
		ACQ_SRC_PATTERN = 2'h3
	} acq_src_e;

	typedef enum logic [2:0] {
		ACQ_M_POST_STOP = 3'h0,
		ACQ_M_FIXPRE_STOP = 3'h1,
		ACQ_M_POST_INF = 3'h2,
		ACQ_M_FIXPRE_INF = 3'h3,
		ACQ_M_VARPRE_STOP = 3'h4,
		ACQ_M_VARPRE_INF = 3'h5
	} acq_mode_e;

	typedef enum logic [1:0] {
		ACQ_R_5US = 2'h0,
		ACQ_R_10US = 2'h1,
		ACQ_R_1000US = 2'h2
	} acq_rate_e;

	typedef enum logic [1:0] {
		ACQ_E_ANALOG = 2'h0,
		ACQ_E_DIGITAL = 2'h1,
		ACQ_E_COUNTER = 2'h2
	} acq_kind_e;

	typedef struct packed {
		acq_kind_e kind;
		logic [1:0] port;
		logic [3:0] gain;
		logic [7:0] chan;
	} acq_entry_s;

	typedef struct packed {
		acq_src_e src;
		logic ana_falling;
		logic dig_edge;
		logic dig_high;
		logic [1:0] pat_port;
		logic [15:0] pat_value;
		logic [15:0] pat_mask;
	} acq_trig_cfg_s;

	typedef struct packed {
		logic post;
		acq_kind_e kind;
		logic [15:0] data;
	} acq_sample_s;

endpackage : acq_pkg

// ### hw/acq_fifo.sv
// Sample buffer between the sequencer and the host side, valid/ready on both ends
`timescale 1ns/100ps
`default_nettype none

module acq_fifo #(
	parameter int unsigned WIDTH = 19,
	parameter int unsigned DEPTH = 32,
	localparam int unsigned AW = $clog2(DEPTH)
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [AW:0] level_o
);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} acq_fifo_st_s;

	acq_fifo_st_s s_r;
	acq_fifo_st_s s_nxt;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	assign in_ready_o = (s_r.cnt != (AW+1)'(DEPTH));
	assign out_valid_o = (s_r.cnt != '0);
	assign out_data_o = mem[s_r.rd];
	assign level_o = s_r.cnt;
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.wr = (s_r.wr == AW'(DEPTH - 1)) ? '0 : s_r.wr + AW'(1);
		end
		if (pop) begin
			s_nxt.rd = (s_r.rd == AW'(DEPTH - 1)) ? '0 : s_r.rd + AW'(1);
		end
		if (push && !pop) begin
			s_nxt.cnt = s_r.cnt + (AW+1)'(1);
		end else if (pop && !push) begin
			s_nxt.cnt = s_r.cnt - (AW+1)'(1);
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Storage carries no reset; only pointers and count do
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[s_r.wr] <= in_data_i;
		end
	end

endmodule : acq_fifo

`default_nettype wire

// ### hw/acq_trig.sv
// Hardware trigger detection: analog comparator crossing, digital line, digital pattern
`timescale 1ns/100ps
`default_nettype none

module acq_trig (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire acq_pkg::acq_trig_cfg_s cfg_i,
	input wire logic soft_i,
	input wire logic cmp_above_i,
	input wire logic dig_trig_i,
	input wire logic [3:0][15:0] dig_port_i,
	output logic hit_o,
	output logic fire_o
);
	typedef struct packed {
		logic cmp_prev;
		logic dig_prev;
		logic hit;
		logic hit_prev;
	} acq_trig_st_s;

	acq_trig_st_s s_r;
	acq_trig_st_s s_nxt;
	logic cmp_hit;
	logic dig_hit;
	logic pat_hit;

	always_comb begin
		s_nxt = s_r;
		s_nxt.cmp_prev = cmp_above_i;
		s_nxt.dig_prev = dig_trig_i;
		cmp_hit = cfg_i.ana_falling ? (s_r.cmp_prev & ~cmp_above_i)
			: (~s_r.cmp_prev & cmp_above_i);
		if (cfg_i.dig_edge) begin
			dig_hit = cfg_i.dig_high ? (~s_r.dig_prev & dig_trig_i)
				: (s_r.dig_prev & ~dig_trig_i);
		end else begin
			dig_hit = (dig_trig_i == cfg_i.dig_high);
		end
		// Mask bit set means the bit is ignored
		pat_hit = (((dig_port_i[cfg_i.pat_port] ^ cfg_i.pat_value)
			& ~cfg_i.pat_mask) == 16'h0000);
		case (cfg_i.src)
			acq_pkg::ACQ_SRC_ANALOG: s_nxt.hit = cmp_hit;
			acq_pkg::ACQ_SRC_DIGITAL: s_nxt.hit = dig_hit;
			acq_pkg::ACQ_SRC_PATTERN: s_nxt.hit = pat_hit;
			default: s_nxt.hit = soft_i;
		endcase
		s_nxt.hit_prev = s_r.hit;
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// One cycle from pin to hit, far inside the latency budget
	assign hit_o = s_r.hit;
	assign fire_o = s_r.hit & ~s_r.hit_prev;

endmodule : acq_trig

`default_nettype wire

// ### hw/acq_seq.sv
// Scan sequencer top: scan table, channel pacing, group interval, triggers, Wishbone registers
`include "acq_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module acq_seq #(
	parameter int unsigned SLOT_SLOW_US = `ACQ_SLOT_SLOW_US,
	parameter int unsigned TABLE_DEPTH = `ACQ_TABLE_DEPTH,
	parameter int unsigned FIFO_DEPTH = `ACQ_FIFO_DEPTH,
	localparam int unsigned IW = $clog2(TABLE_DEPTH),
	localparam int unsigned SW = 10,
	localparam int unsigned LW = $clog2(FIFO_DEPTH) + 1
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [7:0] input_selector_o,
	output logic [3:0] programmable_gain_amp_o,
	output logic conv_start_o,
	input wire logic conv_valid_i,
	input wire logic [15:0] conv_data_i,
	output logic [15:0] trig_level_o,
	output logic [7:0] trig_chan_o,
	input wire logic trig_above_i,
	input wire logic dig_trig_i,
	input wire logic [3:0][15:0] dig_port_i,
	input wire logic [3:0][15:0] cnt_value_i,
	output logic smp_valid_o,
	input wire logic smp_ready_i,
	output acq_pkg::acq_sample_s smp_data_o
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [`ACQ_CTRL_W-1:0] ctrl;
		logic [IW-1:0] tlen;
		logic [31:0] interval;
		logic [23:0] ana;
		logic [31:0] pat;
		logic [15:0] pretrig;
		logic [IW-1:0] taddr;
		logic ack;
		logic [31:0] rdata;
		acq_pkg::acq_state_e state;
		logic [IW-1:0] idx;
		logic [6:0] us_div;
		logic [SW-1:0] slot;
		logic [3:0] gsub;
		logic [31:0] gap;
		logic trig;
		logic [15:0] pre_cnt;
		logic sw_trig;
		logic stop;
		logic busy;
		logic pend;
		acq_pkg::acq_kind_e pend_kind;
		logic [15:0] pend_data;
		logic conv_start;
		logic [7:0] sel;
		logic [3:0] gain;
	} acq_seq_st_s;

	acq_seq_st_s s_r;
	acq_seq_st_s s_nxt;
	logic [15:0] table_mem [TABLE_DEPTH];
	acq_pkg::acq_entry_s ent;
	acq_pkg::acq_trig_cfg_s tcfg;
	acq_pkg::acq_mode_e mode;
	acq_pkg::acq_sample_s push_smp;
	logic [31:0] wval;
	logic [31:0] status;
	logic [SW-1:0] slot_len;
	logic [LW-1:0] fifo_level;
	logic wb_req;
	logic tbl_we;
	logic push;
	logic fifo_rdy;
	logic tick;
	logic at_end;
	logic pre_mode;
	logic stop_mode;
	logic pre_ok;
	logic trig_hit;
	logic trig_fire;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] acq_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel_v);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel_v[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction : acq_merge

	assign ent = acq_pkg::acq_entry_s'(table_mem[s_r.idx]);
	assign mode = acq_pkg::acq_mode_e'(s_r.ctrl[`ACQ_C_MODE +: 3]);
	assign tick = (s_r.us_div == 7'(`ACQ_TICK_CYC - 1));
	assign wb_req = wb_cyc_i & wb_stb_i & ~s_r.ack;

	always_comb begin
		case (acq_pkg::acq_rate_e'(s_r.ctrl[`ACQ_C_RATE +: 2]))
			acq_pkg::ACQ_R_5US: slot_len = SW'(`ACQ_SLOT_FAST_US);
			acq_pkg::ACQ_R_10US: slot_len = SW'(`ACQ_SLOT_MID_US);
			default: slot_len = SW'(SLOT_SLOW_US);
		endcase
	end

	// Sync mode forbids pre-trigger capture whatever mode is chosen
	assign pre_mode = ~s_r.ctrl[`ACQ_C_SYNC] & ((mode == acq_pkg::ACQ_M_FIXPRE_STOP)
		| (mode == acq_pkg::ACQ_M_FIXPRE_INF) | (mode == acq_pkg::ACQ_M_VARPRE_STOP)
		| (mode == acq_pkg::ACQ_M_VARPRE_INF));
	assign stop_mode = (mode == acq_pkg::ACQ_M_POST_STOP) | (mode == acq_pkg::ACQ_M_FIXPRE_STOP)
		| (mode == acq_pkg::ACQ_M_VARPRE_STOP);
	// Fixed modes must gather the pre-trigger count before a trigger counts
	assign pre_ok = ((mode != acq_pkg::ACQ_M_FIXPRE_STOP) && (mode != acq_pkg::ACQ_M_FIXPRE_INF))
		|| (s_r.pre_cnt >= s_r.pretrig);
	assign at_end = (s_r.slot >= slot_len - SW'(1));

	assign status = {7'h00, s_r.idx, 2'h0, fifo_level, 4'h0, s_r.state, s_r.trig,
		(s_r.state != acq_pkg::ACQ_IDLE)};

	assign tcfg.src = acq_pkg::acq_src_e'(s_r.ctrl[`ACQ_C_SRC +: 2]);
	assign tcfg.ana_falling = s_r.ctrl[`ACQ_C_AFALL];
	assign tcfg.dig_edge = s_r.ctrl[`ACQ_C_DEDGE];
	assign tcfg.dig_high = s_r.ctrl[`ACQ_C_DHIGH];
	assign tcfg.pat_port = s_r.ctrl[`ACQ_C_PPORT +: 2];
	assign tcfg.pat_value = s_r.pat[15:0];
	assign tcfg.pat_mask = s_r.pat[`ACQ_P_MASK +: 16];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = wb_req;
		s_nxt.sw_trig = 1'b0;
		s_nxt.stop = 1'b0;
		s_nxt.conv_start = 1'b0;
		s_nxt.us_div = tick ? 7'h00 : s_r.us_div + 7'h01;
		s_nxt.sel = ent.chan;
		s_nxt.gain = ent.gain;
		tbl_we = 1'b0;
		push = 1'b0;
		push_smp = '0;
		wval = 32'h0000_0000;

		// Register bus
		if (wb_req) begin
			s_nxt.rdata = 32'h0000_0000;
			case (wb_adr_i)
				`ACQ_REG_CTRL: s_nxt.rdata = 32'(s_r.ctrl);
				`ACQ_REG_STATUS: s_nxt.rdata = status;
				`ACQ_REG_TLEN: s_nxt.rdata = 32'(s_r.tlen);
				`ACQ_REG_INTERVAL: s_nxt.rdata = s_r.interval;
				`ACQ_REG_ANALOG: s_nxt.rdata = 32'(s_r.ana);
				`ACQ_REG_PATTERN: s_nxt.rdata = s_r.pat;
				`ACQ_REG_PRETRIG: s_nxt.rdata = 32'(s_r.pretrig);
				`ACQ_REG_TADDR: s_nxt.rdata = 32'(s_r.taddr);
				`ACQ_REG_TDATA: s_nxt.rdata = 32'(table_mem[s_r.taddr]);
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end
		if (wb_req && wb_we_i) begin
			case (wb_adr_i)
				`ACQ_REG_CTRL: begin
					wval = acq_merge(32'(s_r.ctrl), wb_dat_i, wb_sel_i);
					s_nxt.ctrl = wval[`ACQ_CTRL_W-1:0];
					s_nxt.sw_trig = wval[`ACQ_C_SWTRIG];
					s_nxt.stop = wval[`ACQ_C_STOP];
				end
				`ACQ_REG_TLEN: begin
					wval = acq_merge(32'(s_r.tlen), wb_dat_i, wb_sel_i);
					s_nxt.tlen = wval[IW-1:0];
				end
				`ACQ_REG_INTERVAL: begin
					s_nxt.interval = acq_merge(s_r.interval, wb_dat_i, wb_sel_i);
				end
				`ACQ_REG_ANALOG: begin
					wval = acq_merge(32'(s_r.ana), wb_dat_i, wb_sel_i);
					s_nxt.ana = wval[23:0];
				end
				`ACQ_REG_PATTERN: begin
					s_nxt.pat = acq_merge(s_r.pat, wb_dat_i, wb_sel_i);
				end
				`ACQ_REG_PRETRIG: begin
					wval = acq_merge(32'(s_r.pretrig), wb_dat_i, wb_sel_i);
					s_nxt.pretrig = wval[15:0];
				end
				`ACQ_REG_TADDR: begin
					wval = acq_merge(32'(s_r.taddr), wb_dat_i, wb_sel_i);
					s_nxt.taddr = wval[IW-1:0];
				end
				`ACQ_REG_TDATA: begin
					// Table writes auto-increment so a whole group loads in one burst
					tbl_we = 1'b1;
					s_nxt.taddr = s_r.taddr + IW'(1);
				end
				default: begin
				end
			endcase
		end

		// Sample delivery; analog result has priority over a held digital or counter one
		if (conv_valid_i && s_r.busy) begin
			push = 1'b1;
			push_smp.post = s_r.trig;
			push_smp.kind = acq_pkg::ACQ_E_ANALOG;
			push_smp.data = conv_data_i;
			s_nxt.busy = 1'b0;
		end else if (s_r.pend) begin
			push = 1'b1;
			push_smp.post = s_r.trig;
			push_smp.kind = s_r.pend_kind;
			push_smp.data = s_r.pend_data;
			s_nxt.pend = 1'b0;
		end
		if (push && !s_r.trig && (s_r.pre_cnt != 16'hFFFF)) begin
			s_nxt.pre_cnt = s_r.pre_cnt + 16'h0001;
		end

		// Sequencer
		case (s_r.state)
			acq_pkg::ACQ_IDLE: begin
				if (s_r.ctrl[`ACQ_C_RUN]) begin
					s_nxt.idx = '0;
					s_nxt.slot = '0;
					s_nxt.trig = ~pre_mode;
					s_nxt.pre_cnt = 16'h0000;
					s_nxt.state = pre_mode ? acq_pkg::ACQ_SCAN : acq_pkg::ACQ_ARM;
				end
			end
			acq_pkg::ACQ_ARM: begin
				if (trig_hit) begin
					s_nxt.slot = '0;
					s_nxt.state = acq_pkg::ACQ_SCAN;
				end
			end
			acq_pkg::ACQ_SCAN: begin
				// A full buffer or an unfinished conversion stretches the slot
				if (tick && at_end && fifo_rdy && !s_r.pend && !s_r.busy) begin
					s_nxt.slot = '0;
					if (ent.kind == acq_pkg::ACQ_E_ANALOG) begin
						s_nxt.conv_start = 1'b1;
						s_nxt.busy = 1'b1;
					end else begin
						s_nxt.pend = 1'b1;
						s_nxt.pend_kind = ent.kind;
						s_nxt.pend_data = (ent.kind == acq_pkg::ACQ_E_DIGITAL)
							? dig_port_i[ent.port] : cnt_value_i[ent.port];
					end
					if (s_r.idx == s_r.tlen) begin
						s_nxt.idx = '0;
						if (s_r.interval != 32'h0000_0000) begin
							s_nxt.gap = 32'h0000_0000;
							s_nxt.gsub = 4'h0;
							s_nxt.state = acq_pkg::ACQ_GAP;
						end
					end else begin
						s_nxt.idx = s_r.idx + IW'(1);
					end
				end else if (tick && !at_end) begin
					s_nxt.slot = s_r.slot + SW'(1);
				end
			end
			acq_pkg::ACQ_GAP: begin
				if (s_r.gap == s_r.interval) begin
					s_nxt.slot = '0;
					s_nxt.state = acq_pkg::ACQ_SCAN;
				end else if (tick) begin
					if (s_r.gsub == 4'(`ACQ_GAP_UNIT_US - 1)) begin
						s_nxt.gsub = 4'h0;
						s_nxt.gap = s_r.gap + 32'h0000_0001;
					end else begin
						s_nxt.gsub = s_r.gsub + 4'h1;
					end
				end
			end
			default: begin
				s_nxt.state = acq_pkg::ACQ_IDLE;
			end
		endcase

		// Trigger decisions while scanning or between groups
		if ((s_r.state == acq_pkg::ACQ_SCAN) || (s_r.state == acq_pkg::ACQ_GAP)) begin
			if (!s_r.trig && trig_hit && pre_ok) begin
				s_nxt.trig = 1'b1;
			end else if (s_r.trig && stop_mode && trig_fire) begin
				s_nxt.ctrl[`ACQ_C_RUN] = 1'b0;
			end
		end

		// Stop command or run cleared ends acquisition; conversion in flight still lands
		if ((s_r.state != acq_pkg::ACQ_IDLE) && (s_r.stop || !s_r.ctrl[`ACQ_C_RUN])) begin
			s_nxt.ctrl[`ACQ_C_RUN] = 1'b0;
			s_nxt.state = acq_pkg::ACQ_IDLE;
			s_nxt.pend = s_r.pend & ~push;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
			s_r.ctrl <= `ACQ_CTRL_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Table has no reset; software loads it before starting
	always_ff @(posedge clock_i) begin
		if (tbl_we) begin
			table_mem[s_r.taddr] <= wb_dat_i[15:0];
		end
	end

	// ----------------------------------------
	// Children and outputs
	// ----------------------------------------
	acq_trig u_trig (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.cfg_i(tcfg),
		.soft_i(s_r.sw_trig),
		.cmp_above_i(trig_above_i),
		.dig_trig_i(dig_trig_i),
		.dig_port_i(dig_port_i),
		.hit_o(trig_hit),
		.fire_o(trig_fire)
	);

	acq_fifo #(
		.WIDTH($bits(acq_pkg::acq_sample_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(push),
		.in_ready_o(fifo_rdy),
		.in_data_i(push_smp),
		.out_valid_o(smp_valid_o),
		.out_ready_i(smp_ready_i),
		.out_data_o(smp_data_o),
		.level_o(fifo_level)
	);

	assign wb_ack_o = s_r.ack;
	assign wb_dat_o = s_r.rdata;
	assign input_selector_o = s_r.sel;
	assign programmable_gain_amp_o = s_r.gain;
	assign conv_start_o = s_r.conv_start;
	assign trig_level_o = s_r.ana[15:0];
	assign trig_chan_o = s_r.ana[`ACQ_A_CHAN +: 8];

endmodule : acq_seq

`default_nettype wire

// ### bench/acq_conv_model.sv
// Converter model: answers each start pulse with a result built from channel and gain
`timescale 1ns/100ps
`default_nettype none

module acq_conv_model (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [9:0] dly_i,
	input wire logic [7:0] input_selector_i,
	input wire logic [3:0] programmable_gain_amp_i,
	input wire logic conv_start_i,
	output logic conv_valid_o,
	output logic [15:0] conv_data_o
);
	logic busy;
	logic [9:0] cnt;
	logic [15:0] res;
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy <= 1'b0;
			cnt <= 10'h000;
			res <= 16'h0000;
			conv_valid_o <= 1'b0;
			conv_data_o <= 16'h0000;
		end else begin
			conv_valid_o <= 1'b0;
			// Stale data toggles so nobody can read it as held
			conv_data_o <= ~conv_data_o;
			if (conv_start_i) begin
				busy <= 1'b1;
				cnt <= dly_i;
				res <= {programmable_gain_amp_i, 4'h0, input_selector_i};
			end else if (busy && cnt == 10'h000) begin
				busy <= 1'b0;
				conv_valid_o <= 1'b1;
				conv_data_o <= res;
			end else if (busy) begin
				cnt <= cnt - 10'h001;
			end
		end
	end
endmodule : acq_conv_model

`default_nettype wire

// ### bench/acq_seq_assertions.sv
// Port-level checker of the scan sequencer and its bind
`timescale 1ns/100ps
`default_nettype none

module acq_seq_chk #(
	parameter int unsigned SLOT_SLOW_US = 1000
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [7:0] input_selector_o,
	input wire logic [3:0] programmable_gain_amp_o,
	input wire logic conv_start_o,
	input wire logic conv_valid_i,
	input wire logic [15:0] trig_level_o,
	input wire logic [7:0] trig_chan_o,
	input wire logic smp_valid_o,
	input wire logic smp_ready_i,
	input wire acq_pkg::acq_sample_s smp_data_o
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	logic [15:0] gap_r;
	logic [23:0] ana_r;
	logic sync_r;
	logic wr_ack;
	assign wr_ack = wb_ack_o && wb_we_i && wb_sel_i == 4'hF;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gap_r <= 16'hFFFF;
			ana_r <= 24'h000000;
			sync_r <= 1'b0;
		end else begin
			if (conv_start_o)
				gap_r <= 16'h0001;
			else if (gap_r != 16'hFFFF)
				gap_r <= gap_r + 16'h0001;
			if (wr_ack && wb_adr_i == 8'h10)
				ana_r <= wb_dat_i[23:0];
			if (wr_ack && wb_adr_i == 8'h00)
				sync_r <= wb_dat_i[1];
		end
	end
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h40 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
		else $error("start pulse too long");
	a_slot_min: assert property (conv_start_o |-> gap_r >= 16'h01F4)
		else $error("slot too short");
	a_sel_hold: assert property (conv_start_o |-> $stable(input_selector_o) && $stable(programmable_gain_amp_o))
		else $error("selector moved at start");
	a_ref_load: assert property (wr_ack && wb_adr_i == 8'h10 |-> ##[1:2] {trig_chan_o, trig_level_o} == ana_r)
		else $error("reference not loaded");
	a_push_next: assert property (conv_valid_i |-> ##[1:2] smp_valid_o)
		else $error("result not buffered");
	a_smp_hold: assert property (smp_valid_o && !smp_ready_i |=> smp_valid_o && $stable(smp_data_o))
		else $error("sample dropped");
	a_sync_post: assert property (smp_valid_o && sync_r |-> smp_data_o.post)
		else $error("pre sample in sync mode");
endmodule : acq_seq_chk

bind acq_seq acq_seq_chk #(.SLOT_SLOW_US(SLOT_SLOW_US)) u_chk (.clock_i(clock_i),
	.rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .input_selector_o(input_selector_o),
	.programmable_gain_amp_o(programmable_gain_amp_o), .conv_start_o(conv_start_o),
	.conv_valid_i(conv_valid_i), .trig_level_o(trig_level_o), .trig_chan_o(trig_chan_o),
	.smp_valid_o(smp_valid_o), .smp_ready_i(smp_ready_i), .smp_data_o(smp_data_o));

`default_nettype wire

// ### bench/tb_acq_seq.sv
// Self-checking bench of the scan sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_acq_seq;
	// ----------------------------------------
	// Hookup
	// ----------------------------------------
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack, cst, cval, sval, above = 1'b0, dtrig = 1'b0, srdy = 1'b1;
	logic [7:0] isel, tchn;
	logic [3:0] gain;
	logic [15:0] cdat, tlvl;
	logic [9:0] dly = 10'h002;
	logic [3:0][15:0] dport = {16'h12A4, 16'hC3A5, 16'h0000, 16'h0000};
	logic [3:0][15:0] cnt = {16'h0000, 16'h0000, 16'h5A0F, 16'h0000};
	acq_pkg::acq_sample_s sdat;
	acq_pkg::acq_sample_s q[$];
	int err_total = 0, cmp_count = 0, cyc_n = 0, starts = 0, gap = 0, t_last = 0;
	always #4 clock_i = ~clock_i;
	acq_seq #(.SLOT_SLOW_US(20)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .input_selector_o(isel),
		.programmable_gain_amp_o(gain), .conv_start_o(cst), .conv_valid_i(cval),
		.conv_data_i(cdat), .trig_level_o(tlvl), .trig_chan_o(tchn), .trig_above_i(above),
		.dig_trig_i(dtrig), .dig_port_i(dport), .cnt_value_i(cnt), .smp_valid_o(sval),
		.smp_ready_i(srdy), .smp_data_o(sdat));
	acq_conv_model u_conv (.clock_i(clock_i), .rst_n_i(rst_n_i), .dly_i(dly),
		.input_selector_i(isel), .programmable_gain_amp_i(gain), .conv_start_i(cst),
		.conv_valid_o(cval), .conv_data_o(cdat));
	always @(posedge clock_i) begin
		cyc_n++;
		if (sval === 1'b1 && srdy === 1'b1)
			q.push_back(sdat);
		if (cst === 1'b1) begin
			starts <= starts + 1;
			gap <= cyc_n - t_last;
			t_last <= cyc_n;
		end
		if (cyc_n == 100000) begin
			err_total++;
			complete_run();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clock_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do begin
			@(posedge clock_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		r = rdat;
		cyc <= 1'b0;
		chk({31'h0, n < 50}, 32'h1);
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		wb(1'b1, a, d, x);
	endtask : wr
	task automatic wait_n(input int n, input int lim, input logic use_q);
		int k;
		k = 0;
		while ((use_q ? q.size() : starts) < n && k < lim) begin
			@(posedge clock_i);
			k++;
		end
		chk({31'h0, k < lim}, 32'h1);
	endtask : wait_n
	task automatic load1(input logic [31:0] e);
		wr(8'h1C, 32'h0);
		wr(8'h20, e);
		wr(8'h08, 32'h0);
	endtask : load1
	task automatic halt;
		wr(8'h00, 32'h8000);
		wr(8'h0C, 32'h0);
		repeat (400) @(posedge clock_i);
		q.delete();
	endtask : halt
	task automatic t_reg;
		logic [31:0] r;
		wr(8'h08, 32'h1FF);
		wb(1'b0, 8'h08, 32'h0, r);
		chk(r, 32'h1FF);
		wb(1'b0, 8'h40, 32'h0, r);
		chk(r, 32'h0);
		wr(8'h10, 32'h0037_8123);
		repeat (3) @(posedge clock_i);
		chk({tchn, 8'h00, tlvl}, 32'h3700_8123);
		$display("test registers done");
	endtask : t_reg
	task automatic t_scan;
		dly <= 10'h12C;
		wr(8'h1C, 32'h0);
		wr(8'h20, 32'h0305);
		wr(8'h20, 32'h6000);
		wr(8'h20, 32'h9000);
		wr(8'h08, 32'h2);
		wr(8'h00, 32'h0401);
		wr(8'h00, 32'h4401);
		wait_n(4, 20000, 1'b1);
		chk({13'h0, q[0]}, 32'h0004_3005);
		chk({13'h0, q[1]}, 32'h0005_C3A5);
		chk({13'h0, q[2]}, 32'h0006_5A0F);
		chk({13'h0, q[3]}, 32'h0004_3005);
		halt();
		dly <= 10'h002;
		$display("test mixed scan done");
	endtask : t_scan
	task automatic t_rate(input logic [1:0] r, input int g, input int us);
		load1(32'h0001);
		wr(8'h0C, 32'(g));
		wr(8'h00, 32'h0401 | (r << 2));
		wr(8'h00, 32'h4401 | (r << 2));
		wait_n(starts + 3, 40000, 1'b0);
		chk({31'h0, gap >= (us + 10 * g - 1) * 125 && gap <= (us + 10 * g + 1) * 125 + 20}, 32'h1);
		halt();
		$display("test rate %0d interval %0d done", r, g);
	endtask : t_rate
	task automatic drv(input int k, input logic a);
		above <= (k == 1) ? !a : a;
		dtrig <= (k == 4) ? !a : a;
		dport[3] <= a ? 16'h77A5 : 16'h12A4;
	endtask : drv
	task automatic t_trig(input int k);
		logic [15:0] ctl [5];
		int s;
		ctl = '{16'h0411, 16'h0451, 16'h05A1, 16'h3431, 16'h0421};
		drv(k, 1'b0);
		load1(32'h0002);
		wr(8'h10, 32'h0002_4000);
		wr(8'h14, 32'hFF00_00A5);
		wr(8'h00, {16'h0, ctl[k]});
		s = starts;
		repeat (300) @(posedge clock_i);
		chk(32'(starts), 32'(s));
		drv(k, 1'b1);
		wait_n(s + 1, 800, 1'b0);
		halt();
		$display("test trigger %0d done", k);
	endtask : t_trig
	task automatic t_pre;
		logic [31:0] r;
		int k;
		load1(32'h0001);
		wr(8'h00, 32'h0603);
		repeat (1500) @(posedge clock_i);
		chk({31'h0, sval}, 32'h0);
		wr(8'h00, 32'h4603);
		wait_n(1, 1000, 1'b1);
		chk({31'h0, q[0].post}, 32'h1);
		halt();
		srdy <= 1'b0;
		wr(8'h00, 32'h0A01);
		k = 0;
		do begin
			repeat (500) @(posedge clock_i);
			wb(1'b0, 8'h04, 32'h0, r);
			k++;
		end while (r[13:8] !== 6'h20 && k < 60);
		repeat (1300) @(posedge clock_i);
		wr(8'h00, 32'h8000);
		wb(1'b0, 8'h04, 32'h0, r);
		chk({26'h0, r[13:8]}, 32'h20);
		srdy <= 1'b1;
		repeat (40) @(posedge clock_i);
		chk(32'(q.size()), 32'h20);
		chk({31'h0, q[0].post}, 32'h0);
		chk({31'h0, sval}, 32'h0);
		wr(8'h00, 32'h0A01);
		wr(8'h00, 32'h4A01);
		q.delete();
		wait_n(2, 3000, 1'b1);
		chk({31'h0, q[1].post}, 32'h1);
		halt();
		$display("test pretrigger and buffer done");
	endtask : t_pre
	task automatic t_stop(input logic [31:0] c);
		logic [31:0] r;
		load1(32'h0001);
		wr(8'h00, c);
		wr(8'h00, c | 32'h4000);
		wait_n(starts + 1, 800, 1'b0);
		wr(8'h00, c | 32'h4000);
		repeat (4) @(posedge clock_i);
		wb(1'b0, 8'h04, 32'h0, r);
		chk({28'h0, r[3:0]}, 32'h2);
		halt();
		$display("test stop event %h done", c);
	endtask : t_stop
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		repeat (8) @(posedge clock_i);
		rst_n_i <= 1'b1;
		t_reg();
		t_scan();
		t_rate(2'h0, 0, 5);
		t_rate(2'h1, 0, 10);
		t_rate(2'h2, 0, 20);
		t_rate(2'h0, 2, 5);
		for (int k = 0; k < 5; k++)
			t_trig(k);
		t_pre();
		t_stop(32'h0001);
		t_stop(32'h0201);
		t_stop(32'h0801);
		complete_run();
	end
endmodule : tb_acq_seq

`default_nettype wire
